// *** ufac_consts.svh ***
// Register offsets, field positions, reset values and timing counts for the FIFO access control block
`ifndef UFAC_CONSTS_SVH
`define UFAC_CONSTS_SVH
`define UFAC_OFF_SIE_STATUS 4'h0
`define UFAC_OFF_FIFO_CTRL 4'h1
`define UFAC_OFF_OUT_EN 4'h2
`define UFAC_OFF_STORED_ADDR 4'h3
`define UFAC_OFF_EP_SELECT 4'h4
`define UFAC_OFF_IRQ_STATUS 4'h5
`define UFAC_OFF_IRQ_MASK 4'h6
`define UFAC_OFF_ACTIVE_ADDR 4'h7
`define UFAC_STS_ADDR_METHOD 0
`define UFAC_STS_ACCESS_ERR 1
`define UFAC_FC_REQUEST 0
`define UFAC_FC_DIR_END 1
`define UFAC_FC_CLEAR 2
`define UFAC_FC_EP3_DBL 3
`define UFAC_FC_EP4_DBL 4
`define UFAC_FC_SETUP_CMD 5
`define UFAC_FC_READY 6
`define UFAC_FC_ZERO_LEN 7
`define UFAC_IRQ_ACCESS_ERR 0
`define UFAC_IRQ_SETUP 1
`define UFAC_IRQ_ZERO_LEN 2
`define UFAC_IRQ_UNDERRUN 3
`define UFAC_RESET_BYTE 8'h00
`define UFAC_READY_DELAY_NS 16
`define UFAC_CLK_PERIOD_NS 8
`define UFAC_READY_CYCLES ((`UFAC_READY_DELAY_NS + `UFAC_CLK_PERIOD_NS - 1) / `UFAC_CLK_PERIOD_NS)
`endif

// *** ufac_pkg.sv ***
// Types shared by the FIFO access control block
package ufac_pkg;
    typedef enum logic [1:0] {
        UFAC_IDLE = 2'b00,
        UFAC_WAIT = 2'b01,
        UFAC_READY = 2'b11,
        UFAC_DONE = 2'b10
    } ufac_acc_state_t;
endpackage

// *** ufac_hs_if.sv ***
// Handshake signals between register file and access sequencer
`timescale 1ns/1ps
interface ufac_hs_if;
    logic request;
    logic dir_end;
    logic clear;
    logic fifo_avail;
    logic ready;
    logic cleared;
    modport regs (output request, output dir_end, output clear, output fifo_avail,
                  input ready, input cleared);
    modport seq (input request, input dir_end, input clear, input fifo_avail,
                 output ready, output cleared);
endinterface

// *** ufac_access_seq.sv ***
// Request/ready sequencer for firmware access to the selected endpoint FIFO
`timescale 1ns/1ps
`include "ufac_consts.svh"
module ufac_access_seq
    import ufac_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    ufac_hs_if.seq hs
);
    localparam int READY_CYC = `UFAC_READY_CYCLES;
    initial begin
        if (READY_CYC < 1 || READY_CYC > 15) $error("ready delay out of range");
    end
    ufac_acc_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic cleared_reg, cleared_next;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        cleared_next = 1'b0;
        unique case (state_reg)
            UFAC_IDLE: begin
                cnt_next = 4'h0;
                if (hs.request) state_next = UFAC_WAIT;
            end
            UFAC_WAIT: begin
                if (!hs.request) begin
                    state_next = UFAC_IDLE;
                end else if (hs.fifo_avail) begin
                    cnt_next = cnt_reg + 4'h1;
                    if (cnt_reg == 4'(READY_CYC - 1)) state_next = UFAC_READY;
                end
            end
            UFAC_READY: begin
                if (!hs.request) state_next = UFAC_DONE;
            end
            UFAC_DONE: state_next = UFAC_IDLE;
        endcase
        // Clear empties the FIFO regardless of ready
        if (hs.clear) begin // [R10]
            cleared_next = 1'b1;
            state_next = hs.request ? UFAC_WAIT : UFAC_IDLE;
            cnt_next = 4'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= UFAC_IDLE;
            cnt_reg <= 4'h0;
            cleared_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cleared_reg <= cleared_next;
        end
    end

    assign hs.ready = (state_reg == UFAC_READY); // [R6]
    assign hs.cleared = cleared_reg;

    AST_READY_NEEDS_REQ: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        hs.ready |-> $past(hs.request)) else $error("ready without request"); // [R6]
    AST_CLEAR_DROPS_READY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        hs.clear |=> !hs.ready ##0 hs.cleared) else $error("clear did not empty"); // [R10]
    COV_READY: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        hs.request ##[1:20] hs.ready);
endmodule // ufac_access_seq

// *** ufac_fifo_access_ctrl.sv ***
// Firmware register file and control for USB endpoint FIFO access
`timescale 1ns/1ps
`include "ufac_consts.svh"

// Functional notes
// [R1] Any FIFO access fault sets one shared error flag; firmware clears it.
// [R2] Address method 1: active address loads after a successful IN read.
// [R3] Address method 0: active address loads as soon as address is written.
// [R4] Firmware clears the address method bit after the next SETUP token.
// [R5] Zero-length packet sets read-only flag; FIFO read clears it.
// [R6] Read-only ready flag shows the selected FIFO is ready for access.
// [R7] Hardware sets setup-command flag for setup data; firmware clears it.
// [R8] Endpoint 3 input FIFO single-buffered at 0, double-buffered at 1.
// [R9] Endpoint 4 output double-buffer bit exists on larger variants only.
// [R10] Clear bit empties the selected FIFO even when not ready.
// [R11] Host read after a clear gets a forced under-run transmit error.
// [R12] Writes: direction flag 1 during write, back to 0 before releasing request.
// [R13] Reads: direction flag 0 during read, set to 1 when finished.
// [R14] Firmware raises request after selecting FIFO, lowers it when done.
// [R15] One output FIFO enable bit per endpoint at its own bit position.
// [R16] Bit 0 of output enable register is the endpoint 0 enable bit.
// [R17] Three-bit select field picks endpoint 0 through 7.
// [R18] Stored address register: seven-bit address plus wakeup enable, resets zero.
// [R19] Firmware waits for ready after request before moving data bytes.
module ufac_fifo_access_ctrl
    import ufac_pkg::*;
#(
    parameter int NUM_EP = 8,
    parameter bit HAS_EP4_DBL = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic sie_access_err_i,
    input wire logic sie_zero_len_i,
    input wire logic sie_setup_i,
    input wire logic sie_in_ack_i,
    input wire logic sie_host_in_i,
    input wire logic fifo_avail_i,
    input wire logic fifo_rd_i,
    output logic [6:0] active_addr_o,
    output logic remote_wakeup_enable_o,
    output logic [2:0] endpoint_select_field_o,
    output logic [7:0] output_fifo_enable_o,
    output logic ep3_in_double_buffer_o,
    output logic ep4_out_double_buffer_o,
    output logic fifo_clear_o,
    output logic force_tx_err_o,
    output logic fifo_ready_o,
    output logic irq_o
);
    initial begin
        if (NUM_EP != 4 && NUM_EP != 6 && NUM_EP != 8) $error("NUM_EP must be 4, 6 or 8");
    end

    localparam logic [7:0] EP_MASK = 8'((1 << NUM_EP) - 1);

    ufac_hs_if hs();

    logic [7:0] fctrl_reg, fctrl_next;
    logic [1:0] sts_reg, sts_next;
    logic [7:0] oen_reg, oen_next;
    logic [7:0] saddr_reg, saddr_next;
    logic [2:0] eps_reg, eps_next;
    logic [6:0] aaddr_reg, aaddr_next;
    logic [3:0] irq_sts_reg, irq_sts_next;
    logic [3:0] irq_msk_reg, irq_msk_next;
    logic [7:0] rdata_reg, rdata_next;
    logic underrun_reg, underrun_next;
    logic ferr_reg, ferr_next;
    logic pend_reg, pend_next;
    logic clr_pulse_reg, clr_pulse_next;
    logic irq_reg, irq_next;

    logic wr_fc, wr_sts, wr_oen, wr_sa, wr_eps, wr_msk, rd_irq;
    logic [3:0] irq_ev;
    logic [7:0] fc_view;

    assign wr_fc = reg_wr_i && reg_addr_i == `UFAC_OFF_FIFO_CTRL;
    assign wr_sts = reg_wr_i && reg_addr_i == `UFAC_OFF_SIE_STATUS;
    assign wr_oen = reg_wr_i && reg_addr_i == `UFAC_OFF_OUT_EN;
    assign wr_sa = reg_wr_i && reg_addr_i == `UFAC_OFF_STORED_ADDR;
    assign wr_eps = reg_wr_i && reg_addr_i == `UFAC_OFF_EP_SELECT;
    assign wr_msk = reg_wr_i && reg_addr_i == `UFAC_OFF_IRQ_MASK;
    assign rd_irq = reg_rd_i && reg_addr_i == `UFAC_OFF_IRQ_STATUS;

    assign hs.request = fctrl_reg[`UFAC_FC_REQUEST];
    assign hs.dir_end = fctrl_reg[`UFAC_FC_DIR_END];
    assign hs.clear = clr_pulse_reg;
    assign hs.fifo_avail = fifo_avail_i;

    ufac_access_seq u_seq (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .hs(hs.seq)
    );

    // Ready is live state, so the readback view splices it in
    always_comb begin
        fc_view = fctrl_reg;
        fc_view[`UFAC_FC_READY] = hs.ready; // [R6]
    end

    // FIFO control register
    always_comb begin
        fctrl_next = fctrl_reg;
        clr_pulse_next = 1'b0;
        if (wr_fc) begin
            fctrl_next[`UFAC_FC_REQUEST] = reg_wdata_i[`UFAC_FC_REQUEST]; // [R14]
            fctrl_next[`UFAC_FC_DIR_END] = reg_wdata_i[`UFAC_FC_DIR_END]; // [R12] [R13]
            fctrl_next[`UFAC_FC_CLEAR] = reg_wdata_i[`UFAC_FC_CLEAR];
            fctrl_next[`UFAC_FC_EP3_DBL] = reg_wdata_i[`UFAC_FC_EP3_DBL]; // [R8]
            fctrl_next[`UFAC_FC_EP4_DBL] = HAS_EP4_DBL & reg_wdata_i[`UFAC_FC_EP4_DBL]; // [R9]
            // Firmware may only clear the setup flag
            if (!reg_wdata_i[`UFAC_FC_SETUP_CMD]) fctrl_next[`UFAC_FC_SETUP_CMD] = 1'b0; // [R7]
            clr_pulse_next = reg_wdata_i[`UFAC_FC_CLEAR] & ~fctrl_reg[`UFAC_FC_CLEAR]; // [R10]
        end
        // Hardware sets win over simultaneous clears
        if (fifo_rd_i) fctrl_next[`UFAC_FC_ZERO_LEN] = 1'b0;
        if (sie_zero_len_i) fctrl_next[`UFAC_FC_ZERO_LEN] = 1'b1; // [R5]
        if (sie_setup_i) fctrl_next[`UFAC_FC_SETUP_CMD] = 1'b1; // [R7]
        fctrl_next[`UFAC_FC_READY] = 1'b0;
    end

    // Status, address and enables
    always_comb begin
        sts_next = sts_reg;
        oen_next = oen_reg;
        saddr_next = saddr_reg;
        eps_next = eps_reg;
        aaddr_next = aaddr_reg;
        pend_next = pend_reg;
        underrun_next = underrun_reg;
        ferr_next = 1'b0;
        if (wr_sts) begin
            sts_next[`UFAC_STS_ADDR_METHOD] = reg_wdata_i[`UFAC_STS_ADDR_METHOD];
            if (!reg_wdata_i[`UFAC_STS_ACCESS_ERR]) sts_next[`UFAC_STS_ACCESS_ERR] = 1'b0;
        end
        if (sie_access_err_i) sts_next[`UFAC_STS_ACCESS_ERR] = 1'b1; // [R1]
        if (wr_oen) oen_next = reg_wdata_i & EP_MASK; // [R15] [R16]
        if (wr_eps) eps_next = reg_wdata_i[2:0]; // [R17]
        if (wr_sa) begin
            saddr_next = reg_wdata_i; // [R18]
            if (!sts_reg[`UFAC_STS_ADDR_METHOD]) aaddr_next = reg_wdata_i[7:1]; // [R3]
            else pend_next = 1'b1;
        end
        if (pend_reg && sie_in_ack_i && sts_reg[`UFAC_STS_ADDR_METHOD]) begin
            aaddr_next = saddr_reg[7:1]; // [R2]
            pend_next = 1'b0;
        end
        // Under-run stands from a clear until the host has been refused once
        if (clr_pulse_reg) underrun_next = 1'b1; // [R11]
        else if (sie_host_in_i && underrun_reg) underrun_next = 1'b0;
        ferr_next = sie_host_in_i && underrun_reg; // [R11]
    end

    // Interrupt status, mask and read data
    always_comb begin
        irq_ev = {ferr_reg, sie_zero_len_i, sie_setup_i, sie_access_err_i};
        irq_sts_next = irq_sts_reg;
        if (rd_irq) irq_sts_next = 4'h0;
        irq_sts_next = irq_sts_next | irq_ev;
        irq_msk_next = wr_msk ? reg_wdata_i[3:0] : irq_msk_reg;
        irq_next = |(irq_sts_next & irq_msk_next);
        rdata_next = 8'h00;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `UFAC_OFF_SIE_STATUS: rdata_next = {6'h00, sts_reg};
                `UFAC_OFF_FIFO_CTRL: rdata_next = fc_view;
                `UFAC_OFF_OUT_EN: rdata_next = oen_reg;
                `UFAC_OFF_STORED_ADDR: rdata_next = saddr_reg;
                `UFAC_OFF_EP_SELECT: rdata_next = {5'h00, eps_reg};
                `UFAC_OFF_IRQ_STATUS: rdata_next = {4'h0, irq_sts_reg};
                `UFAC_OFF_IRQ_MASK: rdata_next = {4'h0, irq_msk_reg};
                `UFAC_OFF_ACTIVE_ADDR: rdata_next = {1'b0, aaddr_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fctrl_reg <= `UFAC_RESET_BYTE;
            sts_reg <= 2'h0;
            oen_reg <= `UFAC_RESET_BYTE;
            saddr_reg <= `UFAC_RESET_BYTE;
            eps_reg <= 3'h0;
            aaddr_reg <= 7'h00;
            pend_reg <= 1'b0;
            underrun_reg <= 1'b0;
            ferr_reg <= 1'b0;
            clr_pulse_reg <= 1'b0;
            irq_sts_reg <= 4'h0;
            irq_msk_reg <= 4'h0;
            irq_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            fctrl_reg <= fctrl_next;
            sts_reg <= sts_next;
            oen_reg <= oen_next;
            saddr_reg <= saddr_next;
            eps_reg <= eps_next;
            aaddr_reg <= aaddr_next;
            pend_reg <= pend_next;
            underrun_reg <= underrun_next;
            ferr_reg <= ferr_next;
            clr_pulse_reg <= clr_pulse_next;
            irq_sts_reg <= irq_sts_next;
            irq_msk_reg <= irq_msk_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
        end
    end

    // Output stage; ready is one flop behind the sequencer
    logic ready_q_reg;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) ready_q_reg <= 1'b0;
        else ready_q_reg <= hs.ready;
    end

    assign reg_rdata_o = rdata_reg;
    assign active_addr_o = aaddr_reg;
    assign remote_wakeup_enable_o = saddr_reg[0];
    assign endpoint_select_field_o = eps_reg;
    assign output_fifo_enable_o = oen_reg;
    assign ep3_in_double_buffer_o = fctrl_reg[`UFAC_FC_EP3_DBL];
    assign ep4_out_double_buffer_o = fctrl_reg[`UFAC_FC_EP4_DBL];
    assign fifo_clear_o = clr_pulse_reg;
    assign force_tx_err_o = ferr_reg;
    assign fifo_ready_o = ready_q_reg;
    assign irq_o = irq_reg;

    AST_ERR_STICKY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sie_access_err_i |=> sts_reg[`UFAC_STS_ACCESS_ERR]) else $error("error flag lost"); // [R1]
    AST_ADDR_IMMEDIATE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_sa && !sts_reg[0] |=> active_addr_o == $past(reg_wdata_i[7:1]))
        else $error("address not adopted"); // [R3]
    AST_ADDR_DEFERRED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_sa && sts_reg[0] && !sie_in_ack_i |=> $stable(active_addr_o))
        else $error("address changed early"); // [R2]
    AST_ADDR_ON_IN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        pend_reg && sts_reg[0] && sie_in_ack_i |=> active_addr_o == $past(saddr_reg[7:1]))
        else $error("address not loaded after IN"); // [R2]
    AST_ZLEN_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sie_zero_len_i |=> fctrl_reg[`UFAC_FC_ZERO_LEN]) else $error("zero length lost"); // [R5]
    AST_ZLEN_CLR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        fifo_rd_i && !sie_zero_len_i |=> !fctrl_reg[`UFAC_FC_ZERO_LEN])
        else $error("zero length not cleared"); // [R5]
    AST_SETUP_SET: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        sie_setup_i |=> fctrl_reg[`UFAC_FC_SETUP_CMD]) else $error("setup flag lost"); // [R7]
    AST_EP4_GATED: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !HAS_EP4_DBL |-> !ep4_out_double_buffer_o) else $error("ep4 bit present"); // [R9]
    AST_UNDERRUN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        fifo_clear_o ##1 sie_host_in_i |=> force_tx_err_o) else $error("no under-run"); // [R11]
    AST_OEN_MASK: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        (output_fifo_enable_o & ~EP_MASK) == 8'h00) else $error("enable beyond variant"); // [R15]
    COV_ADDR_DEFER: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        wr_sa && sts_reg[0] ##[1:50] sie_in_ack_i);
    COV_UNDERRUN: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) force_tx_err_o);
    COV_IRQ: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule // ufac_fifo_access_ctrl

// *** ufac_sie_model.sv ***
// Behavioural model of the serial interface engine and FIFO side facing the block
`timescale 1ns/1ps
module ufac_sie_model (
    input wire logic sys_clk_i,
    output logic [5:0] evt_o,
    output logic avail_o
);
    // Event lines: 0 access fault, 1 zero length, 2 setup, 3 IN acked, 4 host IN, 5 FIFO read
    initial begin
        evt_o = 6'h00;
        avail_o = 1'b0;
    end
    // Pulses last one cycle and start just after an edge, like the engine's strobes
    task automatic pulse(input int idx);
        @(posedge sys_clk_i);
        evt_o[idx] <= 1'b1;
        @(posedge sys_clk_i);
        evt_o[idx] <= 1'b0;
    endtask
    // Availability may lag the request by any number of cycles
    task automatic set_avail(input logic v);
        @(posedge sys_clk_i);
        avail_o <= v;
    endtask
endmodule // ufac_sie_model

// *** usb_fifo_access_control_bench.sv ***
// Self-checking bench for the FIFO access control block
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module usb_fifo_access_control_bench;
    import ufac_pkg::*;
    logic sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i;
    logic [3:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, output_fifo_enable_o, rd;
    logic [6:0] active_addr_o;
    logic [2:0] endpoint_select_field_o;
    logic remote_wakeup_enable_o, ep3_in_double_buffer_o, ep4_out_double_buffer_o;
    logic fifo_clear_o, force_tx_err_o, fifo_ready_o, irq_o, avail;
    logic [5:0] evt;
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    ufac_sie_model sie_u (.sys_clk_i(sys_clk_i), .evt_o(evt), .avail_o(avail));
    ufac_fifo_access_ctrl #(.NUM_EP(8), .HAS_EP4_DBL(1'b1)) dut_u (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .sie_access_err_i(evt[0]), .sie_zero_len_i(evt[1]),
        .sie_setup_i(evt[2]), .sie_in_ack_i(evt[3]), .sie_host_in_i(evt[4]),
        .fifo_avail_i(avail), .fifo_rd_i(evt[5]), .active_addr_o(active_addr_o),
        .remote_wakeup_enable_o(remote_wakeup_enable_o),
        .endpoint_select_field_o(endpoint_select_field_o),
        .output_fifo_enable_o(output_fifo_enable_o),
        .ep3_in_double_buffer_o(ep3_in_double_buffer_o),
        .ep4_out_double_buffer_o(ep4_out_double_buffer_o), .fifo_clear_o(fifo_clear_o),
        .force_tx_err_o(force_tx_err_o), .fifo_ready_o(fifo_ready_o), .irq_o(irq_o));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Cuts a hang short; the whole run needs well under a thousand cycles
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe edge, so sample just past it
    task automatic rdr(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // Pulses rise at the edge on which the calling task returns, so look there first
    task automatic count_hi(input bit tx, output int c);
        c = 0;
        repeat (4) begin
            #1 c += tx ? int'(force_tx_err_o === 1'b1) : int'(fifo_clear_o === 1'b1);
            @(posedge sys_clk_i);
        end
    endtask
    // Ready takes the sequencer's count of available cycles plus the output flop
    task automatic wait_ready();
        n = 0;
        while (fifo_ready_o !== 1'b1 && n < 20) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic t_reset();
        for (int a = 0; a < 8; a++) begin
            rdr(a[3:0], rd);
            `CHK(rd, 8'h00)
        end
        `CHK(active_addr_o, 7'h00)
    endtask
    task automatic t_error_irq();
        sie_u.pulse(0);
        settle();
        `CHK(irq_o, 1'b0)
        wr(4'h6, 8'h01);
        settle();
        `CHK(irq_o, 1'b1)
        rdr(4'h0, rd);
        `CHK(rd, 8'h02)
        rdr(4'h5, rd);
        `CHK(rd, 8'h01)
        settle();
        `CHK(irq_o, 1'b0)
        wr(4'h0, 8'h00);
        rdr(4'h0, rd);
        `CHK(rd, 8'h00)
        wr(4'h6, 8'h00);
    endtask
    task automatic t_address();
        wr(4'h3, 8'ha5);
        settle();
        `CHK(active_addr_o, 7'h52)
        `CHK(remote_wakeup_enable_o, 1'b1)
        wr(4'h0, 8'h01);
        wr(4'h3, 8'h14);
        settle();
        `CHK(active_addr_o, 7'h52)
        sie_u.pulse(3);
        settle();
        `CHK(active_addr_o, 7'h0a)
        sie_u.pulse(2);
        wr(4'h0, 8'h00);
        wr(4'h7, 8'hff);
        wr(4'hf, 8'hff);
        settle();
        `CHK(active_addr_o, 7'h0a)
        rdr(4'hf, rd);
        `CHK(rd, 8'h00)
    endtask
    task automatic t_flags();
        rdr(4'h1, rd);
        `CHK(rd, 8'h20)
        wr(4'h1, 8'hc0);
        rdr(4'h1, rd);
        `CHK(rd, 8'h00)
        sie_u.pulse(1);
        settle();
        rdr(4'h1, rd);
        `CHK(rd, 8'h80)
        sie_u.pulse(5);
        settle();
        rdr(4'h1, rd);
        `CHK(rd, 8'h00)
    endtask
    task automatic t_endpoint();
        for (int e = 0; e < 8; e++) begin
            wr(4'h4, 8'(e));
            settle();
            `CHK(endpoint_select_field_o, 3'(e))
        end
        wr(4'h2, 8'haa);
        settle();
        `CHK(output_fifo_enable_o, 8'haa)
        wr(4'h2, 8'h55);
        rdr(4'h2, rd);
        `CHK(rd, 8'h55)
        `CHK(output_fifo_enable_o, 8'h55)
        wr(4'h1, 8'h18);
        settle();
        `CHK({ep4_out_double_buffer_o, ep3_in_double_buffer_o}, 2'b11)
        wr(4'h1, 8'h08);
        rdr(4'h1, rd);
        `CHK(rd, 8'h08)
        `CHK({ep4_out_double_buffer_o, ep3_in_double_buffer_o}, 2'b01)
        wr(4'h1, 8'h00);
    endtask
    task automatic t_handshake();
        wr(4'h4, 8'h03);
        wr(4'h1, 8'h03);
        settle();
        `CHK(fifo_ready_o, 1'b0)
        sie_u.set_avail(1'b1);
        wait_ready();
        `CHK(fifo_ready_o, 1'b1)
        rdr(4'h1, rd);
        `CHK(rd, 8'h43)
        wr(4'h1, 8'h01);
        wr(4'h1, 8'h00);
        settle();
        `CHK(fifo_ready_o, 1'b0)
        wr(4'h1, 8'h01);
        wait_ready();
        `CHK(fifo_ready_o, 1'b1)
        wr(4'h1, 8'h03);
        wr(4'h1, 8'h00);
        sie_u.set_avail(1'b0);
    endtask
    task automatic t_clear();
        wr(4'h1, 8'h04);
        count_hi(1'b0, n);
        `CHK(n, 1)
        `CHK(fifo_ready_o, 1'b0)
        sie_u.pulse(4);
        count_hi(1'b1, n);
        `CHK(n, 1)
        sie_u.pulse(4);
        count_hi(1'b1, n);
        `CHK(n, 0)
        wr(4'h1, 8'h00);
    endtask
    initial begin
        rst_n_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_error_irq();
        t_address();
        t_flags();
        t_endpoint();
        t_handshake();
        t_clear();
        close_out();
    end
endmodule // usb_fifo_access_control_bench
